// file: core/cfl_chassis_ctrl.sv
// Purpose: Fan level, front lamp and supply gating supervisor
// Assumes: All inputs synchronous and debounced, i_clk 10 MHz
// Notes: Curves are a fixed linear formula; level scales with temperature
`timescale 1ns/1ns
module cfl_chassis_ctrl #(
  parameter int unsigned FAULT_CYCLES = cfl_pkg::FAULT_CYC,
  parameter int unsigned BLINK_CYCLES = cfl_pkg::BLINK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [cfl_pkg::TEMP_W-1:0] i_temp_a,
  input wire logic [cfl_pkg::TEMP_W-1:0] i_temp_b,
  input wire logic [cfl_pkg::TEMP_W-1:0] i_intake_temp,
  input wire logic i_fan_full_sw,
  input wire logic i_fan_fail,
  input wire logic i_volt_out_of_tol,
  input wire logic i_mains_ok,
  input wire logic i_mains_auto_on_mode,
  input wire logic i_button,
  input wire logic i_holdoff_n,
  output logic [cfl_pkg::LVL_W-1:0] o_fan_level,
  output logic o_supply_en,
  output logic o_status_indicator_out,
  output logic o_fault_indicator_out
);
  import cfl_pkg::*;

  typedef struct packed {
    logic [3:0] curve;
    logic mains_auto_on_mode;
    logic [7:0] man_lvl;
    logic [7:0] fan_lvl;
    logic [31:0] rdata;
    logic btn_d;
    logic btn_on;
    logic latched_off;
    logic [CNT_W-1:0] fault_cnt;
    logic [CNT_W-1:0] blink_cnt;
    logic blink;
    logic wt;
    logic rd;
  } cfl_state_t;

  cfl_state_t s_r, s_nxt;
  logic [7:0] hot;
  logic [7:0] curve_lvl;
  logic [8:0] prod;
  cfl_fan_mode_t mode;
  logic wr_acc, rd_acc, addr_ok, on_now;

  assign hot = (i_temp_a > i_temp_b) ? i_temp_a : i_temp_b;
  // Curve n: 30% floor plus slope; higher curves spin harder at same temperature
  assign prod = 9'(({1'b0, hot} >> 1) + 9'(s_r.curve) * 9'd8 + 9'd76);
  assign curve_lvl = prod[8] ? LVL_FULL : prod[7:0];
  assign mode = i_fan_full_sw ? CFL_FAN_FULL : (s_r.mains_auto_on_mode ? CFL_FAN_MANUAL : CFL_FAN_CURVE);

  assign addr_ok = (i_paddr == REG_CTRL) || (i_paddr == REG_MANLVL) ||
                   (i_paddr == REG_STATUS) || (i_paddr == REG_TEMP);
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && !i_penable && !i_pwrite;
  // Supply is off while hold-off grounded, combinationally, so drop is immediate
  assign on_now = i_mains_ok && i_holdoff_n && !s_r.latched_off &&
                  (i_mains_auto_on_mode || s_r.btn_on);

  always_comb begin
    s_nxt = s_r;
    s_nxt.btn_d = i_button;
    if (wr_acc && i_paddr == REG_CTRL) begin
      s_nxt.curve = i_pwdata[CTRL_CURVE_LSB +: 4];
      s_nxt.mains_auto_on_mode = i_pwdata[CTRL_MAN_BIT];
    end
    if (wr_acc && i_paddr == REG_MANLVL) begin
      s_nxt.man_lvl = i_pwdata[7:0];
    end
    unique case (mode)
      CFL_FAN_FULL: s_nxt.fan_lvl = LVL_FULL;
      CFL_FAN_MANUAL: s_nxt.fan_lvl = s_r.man_lvl;
      CFL_FAN_CURVE: s_nxt.fan_lvl = curve_lvl;
    endcase
    if (i_button && !s_r.btn_d) begin
      s_nxt.btn_on = !s_r.btn_on;
      s_nxt.latched_off = 1'b0;
    end
    if (!i_mains_ok) begin
      s_nxt.btn_on = 1'b0;
      s_nxt.latched_off = 1'b0;
    end
    // Fault timer; a latched voltage trip needs a button press or mains cycle
    if (i_volt_out_of_tol && o_supply_en) begin
      if (s_r.fault_cnt >= CNT_W'(FAULT_CYCLES)) begin
        s_nxt.latched_off = 1'b1;
        s_nxt.btn_on = 1'b0;
      end else begin
        s_nxt.fault_cnt = s_r.fault_cnt + 1'b1;
      end
    end else if (!s_r.latched_off) begin
      s_nxt.fault_cnt = '0;
    end
    if (s_r.blink_cnt >= CNT_W'(BLINK_CYCLES - 1)) begin
      s_nxt.blink_cnt = '0;
      s_nxt.blink = !s_r.blink;
    end else begin
      s_nxt.blink_cnt = s_r.blink_cnt + 1'b1;
    end
    s_nxt.wt = 1'b0;
    s_nxt.rd = 1'b0;
    if (s_r.latched_off || (on_now && i_volt_out_of_tol)) begin
      s_nxt.rd = s_r.blink;
    end else if (!on_now) begin
      s_nxt.wt = 1'b0;
    end else if (i_fan_fail) begin
      s_nxt.rd = 1'b1;
    end else if (i_intake_temp > HOT_LIMIT_C) begin
      s_nxt.wt = s_r.blink;
    end else begin
      s_nxt.wt = 1'b1;
    end
    s_nxt.rdata = '0;
    if (rd_acc) begin
      unique case (i_paddr)
        REG_CTRL: s_nxt.rdata = {27'h000_0000, s_r.mains_auto_on_mode, s_r.curve};
        REG_MANLVL: s_nxt.rdata = {24'h00_0000, s_r.man_lvl};
        REG_STATUS: s_nxt.rdata = {24'h00_0000, s_r.latched_off, o_supply_en,
                                   i_fan_fail, i_volt_out_of_tol, s_r.fan_lvl[7:4]};
        REG_TEMP: s_nxt.rdata = {16'h0000, i_intake_temp, hot};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '{curve: CURVE_RST, mains_auto_on_mode: 1'b0, man_lvl: MANLVL_RST, fan_lvl: LVL_FULL,
               rdata: '0, btn_d: 1'b0, btn_on: 1'b0, latched_off: 1'b0,
               fault_cnt: '0, blink_cnt: '0, blink: 1'b0, wt: 1'b0, rd: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata = s_r.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;
  assign o_fan_level = s_r.fan_lvl;
  assign o_supply_en = on_now;
  assign o_status_indicator_out = s_r.wt;
  assign o_fault_indicator_out = s_r.rd;

  // Hold-off pulled low kills the supply in the same cycle
  property p_holdoff;
    @(posedge i_clk) disable iff (i_rst) !i_holdoff_n |-> !o_supply_en;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("supply on while held off");

  property p_full;
    @(posedge i_clk) disable iff (i_rst) i_fan_full_sw[*2] |-> o_fan_level == 8'hFF;
  endproperty
  a_full: assert property (p_full) else $error("full speed not applied");

  property p_auto_on;
    @(posedge i_clk) disable iff (i_rst)
      (i_mains_ok && i_holdoff_n && i_mains_auto_on_mode && !s_r.latched_off) |-> o_supply_en;
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("auto mode did not power");

  property p_off_dark;
    @(posedge i_clk) disable iff (i_rst)
      (!o_supply_en && !s_r.latched_off)[*2] |-> !o_status_indicator_out;
  endproperty
  a_off_dark: assert property (p_off_dark) else $error("white lit while off");

  property p_fanfail;
    @(posedge i_clk) disable iff (i_rst)
      (o_supply_en && i_fan_fail && !i_volt_out_of_tol) |=> (o_fault_indicator_out ||
      !$past(o_supply_en)) && !o_status_indicator_out;
  endproperty
  a_fanfail: assert property (p_fanfail) else $error("fan failure not shown red");

  property p_normal;
    @(posedge i_clk) disable iff (i_rst)
      (o_supply_en && !i_fan_fail && !i_volt_out_of_tol && i_intake_temp <= 8'd55)
      |=> o_status_indicator_out && !o_fault_indicator_out;
  endproperty
  a_normal: assert property (p_normal) else $error("normal state not solid white");

  sequence s_ctrl_wr;
    i_psel && i_penable && i_pwrite && i_paddr == 8'h00;
  endsequence
  property p_curve;
    @(posedge i_clk) disable iff (i_rst) s_ctrl_wr |=> s_r.curve == $past(i_pwdata[3:0]);
  endproperty
  a_curve: assert property (p_curve) else $error("curve select not stored");

  property p_hot;
    @(posedge i_clk) disable iff (i_rst)
      (o_supply_en && !i_fan_fail && !i_volt_out_of_tol && i_intake_temp > 8'd55)
      |=> !o_fault_indicator_out;
  endproperty
  a_hot: assert property (p_hot) else $error("red lit on overtemperature");

  // Overtemperature blink follows the shared blink phase
  property p_hot_blink;
    @(posedge i_clk) disable iff (i_rst)
      (o_supply_en && !i_fan_fail && !i_volt_out_of_tol && i_intake_temp > HOT_LIMIT_C)
      |=> o_status_indicator_out == $past(s_r.blink);
  endproperty
  a_hot_blink: assert property (p_hot_blink) else $error("white not blinking when hot");

  property p_hottest;
    @(posedge i_clk) disable iff (i_rst) (hot >= i_temp_a) && (hot >= i_temp_b);
  endproperty
  a_hottest: assert property (p_hottest) else $error("fan input not the hottest");

  property p_no_mains;
    @(posedge i_clk) disable iff (i_rst) !i_mains_ok |-> !o_supply_en;
  endproperty
  a_no_mains: assert property (p_no_mains) else $error("supply on without mains");

  // Front button rising edge, seen with mains present and no voltage fault
  sequence s_btn_rise;
    i_button && !s_r.btn_d && i_mains_ok && !i_volt_out_of_tol;
  endsequence
  property p_btn_toggle;
    @(posedge i_clk) disable iff (i_rst) s_btn_rise |=> s_r.btn_on != $past(s_r.btn_on);
  endproperty
  a_btn_toggle: assert property (p_btn_toggle) else $error("button did not toggle");

  property p_btn_unlatch;
    @(posedge i_clk) disable iff (i_rst) s_btn_rise |=> !s_r.latched_off;
  endproperty
  a_btn_unlatch: assert property (p_btn_unlatch) else $error("button left trip latched");

  property p_manual;
    @(posedge i_clk) disable iff (i_rst)
      (!i_fan_full_sw && s_r.mains_auto_on_mode) |=> o_fan_level == $past(s_r.man_lvl);
  endproperty
  a_manual: assert property (p_manual) else $error("manual level not applied");

  // Curve mode never drops below the floor level
  property p_curve_floor;
    @(posedge i_clk) disable iff (i_rst)
      (!i_fan_full_sw && !s_r.mains_auto_on_mode) |=> o_fan_level >= 8'h4C;
  endproperty
  a_curve_floor: assert property (p_curve_floor) else $error("curve level under floor");

  // Fault timer expiry with supply still on
  sequence s_volt_expired;
    i_volt_out_of_tol && o_supply_en && (s_r.fault_cnt >= CNT_W'(FAULT_CYCLES));
  endsequence
  property p_fault_trip;
    @(posedge i_clk) disable iff (i_rst) s_volt_expired |=> s_r.latched_off && !o_supply_en;
  endproperty
  a_fault_trip: assert property (p_fault_trip) else $error("voltage fault did not trip");

  property p_trip_dark;
    @(posedge i_clk) disable iff (i_rst) s_r.latched_off |=> !o_status_indicator_out;
  endproperty
  a_trip_dark: assert property (p_trip_dark) else $error("white lit after trip");

  property p_volt_lamp;
    @(posedge i_clk) disable iff (i_rst)
      (o_supply_en && i_volt_out_of_tol)
      |=> !o_status_indicator_out && o_fault_indicator_out == $past(s_r.blink);
  endproperty
  a_volt_lamp: assert property (p_volt_lamp) else $error("voltage fault not red blink");

  property p_mains_unlatch;
    @(posedge i_clk) disable iff (i_rst) !i_mains_ok |=> !s_r.latched_off;
  endproperty
  a_mains_unlatch: assert property (p_mains_unlatch) else $error("trip kept over mains loss");

  property p_blink_flip;
    @(posedge i_clk) disable iff (i_rst)
      s_r.blink_cnt == CNT_W'(BLINK_CYCLES - 1) |=> s_r.blink != $past(s_r.blink);
  endproperty
  a_blink_flip: assert property (p_blink_flip) else $error("blink did not flip");

  property p_blink_hold;
    @(posedge i_clk) disable iff (i_rst)
      s_r.blink_cnt < CNT_W'(BLINK_CYCLES - 1) |=> $stable(s_r.blink);
  endproperty
  a_blink_hold: assert property (p_blink_hold) else $error("blink flipped early");

  // Unmapped reads return zero so software never sees stale data
  property p_unmapped_rd;
    @(posedge i_clk) disable iff (i_rst)
      (i_psel && !i_penable && !i_pwrite && !addr_ok) |=> o_prdata == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
endmodule

// file: core/cfl_pkg.sv
// Purpose: Constants for the chassis fan, lamp and power supervisor
// Assumes: 10 MHz clock, APB register access
// Notes: Temperatures in whole degrees C, fan level 0..255 (255 = 100%)
package cfl_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TEMP_W = 8;
  localparam int unsigned LVL_W = 8;
  localparam int unsigned NCURVE = 16;
  localparam logic [3:0] CURVE_RST = 4'h5;
  localparam logic [7:0] LVL_FULL = 8'hFF;
  localparam logic [7:0] HOT_LIMIT_C = 8'd55;
  localparam int unsigned FAULT_TIME_MS = 1000;
  localparam int unsigned FAULT_CYC = CLK_HZ / 1000 * FAULT_TIME_MS;
  localparam int unsigned BLINK_TIME_MS = 500;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_TIME_MS;
  localparam int unsigned CNT_W = 32;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MANLVL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TEMP = 8'h0C;
  // Control fields
  localparam int unsigned CTRL_CURVE_LSB = 0;
  localparam int unsigned CTRL_MAN_BIT = 4;
  localparam logic [7:0] MANLVL_RST = 8'h80;
  typedef enum logic [1:0] {CFL_FAN_CURVE, CFL_FAN_MANUAL, CFL_FAN_FULL} cfl_fan_mode_t;
endpackage

// file: sim/cfl_chassis_ctrl_tb.sv
// Purpose: Self-checking bench for the chassis supervisor
// Assumes: Short fault and blink counts
// Notes: Comb supply enable is sampled one edge after its inputs change
`timescale 1ns/1ns
module cfl_chassis_ctrl_tb;
  import cfl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, ta = 8'h28, tb = 8'h64, tin = 8'h14, lvl;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic ff = 1'b0, volt = 1'b0, mains = 1'b1, press = 1'b0, au = 1'b1, full = 1'b0;
  logic peer = 1'b0, btn, mode, fsw, hn, sup, wht, red;
  int error_cnt = 0;
  int cmp_count = 0;
  int w, r;
  always #50 i_clk = ~i_clk;
  cfl_chassis_ctrl #(.FAULT_CYCLES(20), .BLINK_CYCLES(4)) u_cfl_chassis_ctrl (.i_clk(i_clk),
    .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_temp_a(ta), .i_temp_b(tb), .i_intake_temp(tin), .i_fan_full_sw(fsw),
    .i_fan_fail(ff), .i_volt_out_of_tol(volt), .i_mains_ok(mains),
    .i_mains_auto_on_mode(mode), .i_button(btn), .i_holdoff_n(hn), .o_fan_level(lvl),
    .o_supply_en(sup), .o_status_indicator_out(wht), .o_fault_indicator_out(red));
  cfl_far_side u_cfl_far_side (.i_clk(i_clk), .i_press(press), .i_auto(au), .i_full(full),
    .i_peer_hold(peer), .o_button(btn), .o_auto(mode), .o_full_sw(fsw), .o_holdoff_n(hn));
  task automatic chk(input string s, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    // Slave may stretch; never assume a count
    while (pready !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic lamps(input int n);
    cyc(2);
    w = 0;
    r = 0;
    repeat (n) begin
      @(posedge i_clk);
      w += int'(wht);
      r += int'(red);
    end
  endtask
  task automatic push();
    press <= 1'b1;
    @(posedge i_clk);
    press <= 1'b0;
    cyc(4);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(5000);
    error_cnt++;
    summarize();
  end
  initial begin
    cyc(3);
    i_rst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    chk("ctrl", rd, 32'(CURVE_RST));
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
    chk("ready", 32'(pready), 32'h0000_0001);
    cyc(2);
    chk("hot b", 32'(lvl), 32'h0000_00A6);
    ta <= 8'h64;
    tb <= 8'h28;
    apb(1'b0, REG_TEMP, 32'h0000_0000);
    chk("temp", rd[15:0], {tin, 8'h64});
    chk("hot a", 32'(lvl), 32'h0000_00A6);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, REG_CTRL, 32'(c));
      cyc(2);
      chk("curve", 32'(lvl), 32'(126 + 8 * c));
    end
    ta <= 8'hC8;
    cyc(2);
    chk("clip", 32'(lvl), 32'h0000_00FF);
    ta <= 8'h64;
    apb(1'b1, REG_MANLVL, 32'h0000_0033);
    apb(1'b1, REG_CTRL, 32'h0000_0015);
    cyc(2);
    chk("manual", 32'(lvl), 32'h0000_0033);
    full <= 1'b1;
    cyc(3);
    chk("full", 32'(lvl), 32'(LVL_FULL));
    full <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0000_0005);
    $display("fan tests done");
    cyc(1);
    chk("auto on", 32'(sup), 32'h1);
    tin <= 8'h37;
    lamps(16);
    chk("normal", {w, r}, {32'd16, 32'd0});
    peer <= 1'b1;
    cyc(1);
    chk("holdoff", 32'(sup), 32'h0);
    lamps(8);
    chk("off", {w, r}, {32'd0, 32'd0});
    peer <= 1'b0;
    cyc(1);
    chk("release", 32'(sup), 32'h1);
    tin <= 8'h3C;
    lamps(16);
    chk("hot", {w, r}, {32'd8, 32'd0});
    ff <= 1'b1;
    lamps(8);
    chk("fan fail", {w, r}, {32'd0, 32'd8});
    volt <= 1'b1;
    lamps(8);
    chk("volt", {w, r}, {32'd0, 32'd4});
    cyc(1);
    chk("volt early", 32'(sup), 32'h1);
    cyc(15);
    cyc(1);
    chk("volt trip", 32'(sup), 32'h0);
    {volt, ff, tin} <= {2'b00, 8'h14};
    lamps(8);
    chk("latched", {w, r}, {32'd0, 32'd4});
    push();
    chk("unlatch", 32'(sup), 32'h1);
    $display("lamp and fault tests done");
    au <= 1'b0;
    push();
    chk("btn off", 32'(sup), 32'h0);
    push();
    chk("btn on", 32'(sup), 32'h1);
    mains <= 1'b0;
    cyc(1);
    chk("no mains", 32'(sup), 32'h0);
    $display("power tests done");
    summarize();
  end
endmodule

// file: sim/cfl_far_side.sv
// Purpose: Far side model: front button, rear switches, chained peer
// Assumes: Commands come from the bench in the i_clk domain
// Notes: A press request gives a two cycle button pulse
`timescale 1ns/1ns
module cfl_far_side (
  input wire logic i_clk,
  input wire logic i_press,
  input wire logic i_auto,
  input wire logic i_full,
  input wire logic i_peer_hold,
  output logic o_button,
  output logic o_auto,
  output logic o_full_sw,
  output logic o_holdoff_n
);
  logic [1:0] hold_r = 2'h0;
  always @(posedge i_clk) begin
    hold_r <= i_press ? 2'h3 : {1'b0, hold_r[1]};
  end
  assign o_button = hold_r[0];
  assign o_auto = i_auto;
  assign o_full_sw = i_full;
  // Any chained party grounding the line wins
  assign o_holdoff_n = ~i_peer_hold;
endmodule
